/* hw/cmps_pkg.sv */
// Function
// - Rectifier drives stay off until the soft-start level flag is set.
// - Second rectifier drive only active with the half duty limit.
// - Unconnected dead-time inputs give the minimum dead time.
// - Dead time applies only after soft start has finished.
// - Current sense is ignored for a blanking interval after primary rise.
// - Fixed variant uses a fixed blanking interval and fixed dead time.
// - Primary on-time is at least blanking interval plus a logic delay, unless the duty limit or the next cycle start ends it sooner.
// - Skip a pulse when error level is low and last duty under a quarter.
// - While skipping, rectifiers on after soft start, off during it.
// - In half duty mode both primaries skip equal numbers of pulses.
// - Duty limit strap decodes rail, open and ground as full, 75, 50.
// - Second primary drive only active with the half duty limit.
// - With 75 percent and external clock, limit follows clock low phase.
// - Primary set at cycle start, cleared by the peak current comparator.
// - Current limit trip ends the pulse and signals the hiccup event.
// - External clock runs at twice switching rate; two periods per cycle.
// - The synchronisation clock is inverted before timing cycles.
package cmps_pkg;

    localparam int CLK_NS = 10;
    localparam int DEAD_MIN_NS = 8;
    localparam int FIXED_NS = 50;
    localparam int CNT_W = 16;

    // Least times round up to whole cycles
    localparam logic [7:0] DEAD_MIN_CYC =
        8'((DEAD_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] FIXED_CYC = 8'((FIXED_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] LOGIC_DLY_CYC = 8'h01;
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // Duty limit strap sense codes
    localparam logic [1:0] DLS_GND = 2'h0;
    localparam logic [1:0] DLS_RAIL = 2'h1;
    localparam logic [1:0] DLS_FLOAT = 2'h2;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_LEAD = 5'h02,
        S_ON = 5'h04,
        S_TRAIL = 5'h08,
        S_REST = 5'h10
    } cmps_state_t;

    typedef struct packed {
        logic ext_sync_mode;
        logic blank_fixed;
        logic dead_float;
        logic [1:0] duty_limit_select;
        logic [7:0] blank_time_set;
        logic [3:0] dead_time_a_set;
        logic [3:0] dead_time_b_set;
    } cmps_cfg_t;

    typedef struct packed {
        logic ss_done;
        logic comp_low;
        logic pwm_trip;
        logic ilim;
    } cmps_cmp_t;

    typedef struct packed {
        logic primary_drive_a;
        logic primary_drive_b;
        logic rectifier_drive_a;
        logic rectifier_drive_b;
    } cmps_drive_t;

endpackage : cmps_pkg

/* hw/cmps_sync.sv */
`timescale 1ns/100ps
module cmps_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // Two flip-flops per bit
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_r;
        logic hold_r;
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                meta_r <= 1'b0;
                hold_r <= 1'b0;
            end else begin
                meta_r <= d_i[i];
                hold_r <= meta_r;
            end
        end
        assign q_o[i] = hold_r;
    end

endmodule : cmps_sync

/* hw/cmps_top.sv */
`timescale 1ns/100ps
module cmps_top (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire cmps_pkg::cmps_cfg_t cfg_i,
    input wire cmps_pkg::cmps_cmp_t cmp_i,
    input wire logic sync_clk_i,
    input wire logic osc_clk_i,
    output cmps_pkg::cmps_drive_t drive_o,
    output logic ocp_event_o,
    output logic skip_o
);

    localparam int SW = $bits(cmps_pkg::cmps_cfg_t)
        + $bits(cmps_pkg::cmps_cmp_t) + 2;

    logic [SW-1:0] sync_w;
    cmps_pkg::cmps_cfg_t cfg_s;
    cmps_pkg::cmps_cmp_t cmp_s;
    logic sync_s;
    logic osc_s;

    // All pin inputs pass two flip-flops
    cmps_sync #(.W(SW)) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i({cfg_i, cmp_i, sync_clk_i, osc_clk_i}),
        .q_o(sync_w)
    );
    assign {cfg_s, cmp_s, sync_s, osc_s} = sync_w;

    // Timing group state
    logic sel_d_r, sel_d_nxt;
    logic phase_r, phase_nxt;
    logic [15:0] per_cnt_r, per_cnt_nxt;
    logic [15:0] period_r, period_nxt;
    logic start_pend_r, start_pend_nxt;
    logic [1:0] strap_cnt_r, strap_cnt_nxt;
    logic [1:0] dls_r, dls_nxt;
    logic dls_vld_r, dls_vld_nxt;
    logic sel_w, rise_w, fall75_w, cycle_start_w, take_w;

    // Sequencer group state
    cmps_pkg::cmps_state_t st_r, st_nxt;
    logic [7:0] dcnt_r, dcnt_nxt;
    logic [15:0] on_cnt_r, on_cnt_nxt;
    logic [15:0] prev_on_r, prev_on_nxt;
    logic which_b_r, which_b_nxt;
    logic nxt_b_r, nxt_b_nxt;
    logic skip_pair_r, skip_pair_nxt;
    cmps_pkg::cmps_drive_t drive_nxt;
    logic ocp_nxt, skip_nxt;

    logic half_w, full_w;
    logic [7:0] blank_w, lead_w, trail_w;
    logic [15:0] min_on_w, on_inc_w, lim75_w;
    logic skip_cond_w, skip_go_w, past_blank_w, lim_hit_w, busy_w;

    // Cycle clock selection and edges
    // Edges ignored until strap valid: sync flops leave reset at 0, which
    // would otherwise look like a false clock edge
    always_comb begin
        sel_w = cfg_s.ext_sync_mode ? ~sync_s : osc_s;
        rise_w = sel_w & ~sel_d_r & dls_vld_r;
        fall75_w = ~sel_w & sel_d_r & ~phase_r & dls_vld_r;
        cycle_start_w = rise_w & ~phase_r;
    end

    // Period measure, pending start and strap capture
    always_comb begin
        sel_d_nxt = sel_w;
        phase_nxt = rise_w ? ~phase_r : phase_r;
        per_cnt_nxt = cycle_start_w ? 16'h0000 : per_cnt_r + 16'h0001;
        period_nxt = cycle_start_w ? per_cnt_r + 16'h0001 : period_r;
        start_pend_nxt = cycle_start_w | (start_pend_r & ~take_w);
        strap_cnt_nxt = strap_cnt_r;
        dls_nxt = dls_r;
        dls_vld_nxt = dls_vld_r;
        if (!dls_vld_r) begin
            if (strap_cnt_r == cmps_pkg::STRAP_WAIT) begin
                dls_nxt = cfg_s.duty_limit_select;
                dls_vld_nxt = 1'b1;
            end else begin
                strap_cnt_nxt = strap_cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sel_d_r <= 1'b0;
            phase_r <= 1'b0;
            per_cnt_r <= 16'h0000;
            period_r <= cmps_pkg::PERIOD_RST;
            start_pend_r <= 1'b0;
            strap_cnt_r <= 2'h0;
            dls_r <= cmps_pkg::DLS_FLOAT;
            dls_vld_r <= 1'b0;
        end else begin
            sel_d_r <= sel_d_nxt;
            phase_r <= phase_nxt;
            per_cnt_r <= per_cnt_nxt;
            period_r <= period_nxt;
            start_pend_r <= start_pend_nxt;
            strap_cnt_r <= strap_cnt_nxt;
            dls_r <= dls_nxt;
            dls_vld_r <= dls_vld_nxt;
        end
    end

    // Mode decode, timing choices and pulse end terms
    always_comb begin
        half_w = dls_r == cmps_pkg::DLS_GND;
        full_w = dls_r == cmps_pkg::DLS_RAIL;
        blank_w = cfg_s.blank_fixed ? cmps_pkg::FIXED_CYC
            : cfg_s.blank_time_set;
        if (cfg_s.blank_fixed) begin
            lead_w = cmps_pkg::FIXED_CYC;
            trail_w = cmps_pkg::FIXED_CYC;
        end else if (cfg_s.dead_float) begin
            lead_w = cmps_pkg::DEAD_MIN_CYC;
            trail_w = cmps_pkg::DEAD_MIN_CYC;
        end else begin
            lead_w = {4'h0, cfg_s.dead_time_b_set};
            trail_w = {4'h0, cfg_s.dead_time_a_set};
        end
        if (lead_w == 8'h00) lead_w = cmps_pkg::DEAD_MIN_CYC;
        if (trail_w == 8'h00) trail_w = cmps_pkg::DEAD_MIN_CYC;
        min_on_w = {8'h00, blank_w} + {8'h00, cmps_pkg::LOGIC_DLY_CYC};
        on_inc_w = on_cnt_r + 16'h0001;
        past_blank_w = on_inc_w >= min_on_w;
        lim75_w = period_r - {2'h0, period_r[15:2]};
        if (full_w) begin
            lim_hit_w = 1'b0;
        end else if (half_w) begin
            lim_hit_w = on_inc_w >= {1'h0, period_r[15:1]};
        end else if (cfg_s.ext_sync_mode) begin
            lim_hit_w = fall75_w;
        end else begin
            lim_hit_w = on_inc_w >= lim75_w;
        end
        skip_cond_w = cmp_s.comp_low
            & ({prev_on_r, 2'h0} < {2'h0, period_r});
        skip_go_w = (half_w & nxt_b_r) ? skip_pair_r : skip_cond_w;
        take_w = (st_r == cmps_pkg::S_IDLE || st_r == cmps_pkg::S_REST)
            & start_pend_r & dls_vld_r;
    end

    // Pulse sequencer
    always_comb begin
        st_nxt = st_r;
        dcnt_nxt = dcnt_r;
        on_cnt_nxt = on_cnt_r;
        prev_on_nxt = prev_on_r;
        which_b_nxt = which_b_r;
        nxt_b_nxt = nxt_b_r;
        skip_pair_nxt = skip_pair_r;
        ocp_nxt = 1'b0;
        skip_nxt = 1'b0;
        case (st_r)
            cmps_pkg::S_IDLE, cmps_pkg::S_REST: begin
                if (take_w) begin
                    which_b_nxt = half_w & nxt_b_r;
                    nxt_b_nxt = half_w & ~nxt_b_r;
                    if (!(half_w & nxt_b_r)) skip_pair_nxt = skip_cond_w;
                    on_cnt_nxt = 16'h0000;
                    if (skip_go_w) begin
                        st_nxt = cmps_pkg::S_REST;
                        prev_on_nxt = 16'h0000;
                        skip_nxt = 1'b1;
                    end else if (cmp_s.ss_done) begin
                        st_nxt = cmps_pkg::S_LEAD;
                        dcnt_nxt = lead_w;
                    end else begin
                        st_nxt = cmps_pkg::S_ON;
                    end
                end
            end
            cmps_pkg::S_LEAD: begin
                dcnt_nxt = dcnt_r - 8'h01;
                if (dcnt_r <= 8'h01) st_nxt = cmps_pkg::S_ON;
            end
            cmps_pkg::S_ON: begin
                on_cnt_nxt = on_inc_w;
                ocp_nxt = past_blank_w & cmp_s.ilim;
                if (start_pend_r | lim_hit_w
                    | (past_blank_w & (cmp_s.pwm_trip | cmp_s.ilim))) begin
                    prev_on_nxt = on_inc_w;
                    if (cmp_s.ss_done) begin
                        st_nxt = cmps_pkg::S_TRAIL;
                        dcnt_nxt = trail_w;
                    end else begin
                        st_nxt = cmps_pkg::S_REST;
                    end
                end
            end
            cmps_pkg::S_TRAIL: begin
                dcnt_nxt = dcnt_r - 8'h01;
                if (dcnt_r <= 8'h01) st_nxt = cmps_pkg::S_REST;
            end
            default: st_nxt = cmps_pkg::S_IDLE;
        endcase
        busy_w = st_nxt == cmps_pkg::S_LEAD || st_nxt == cmps_pkg::S_ON
            || st_nxt == cmps_pkg::S_TRAIL;
        drive_nxt.primary_drive_a = st_nxt == cmps_pkg::S_ON & ~which_b_nxt;
        drive_nxt.primary_drive_b = st_nxt == cmps_pkg::S_ON & which_b_nxt
            & half_w;
        // Rectifiers on outside own pulse, only after soft start
        drive_nxt.rectifier_drive_a = cmp_s.ss_done & dls_vld_r
            & st_nxt != cmps_pkg::S_IDLE
            & ~(busy_w & ~which_b_nxt);
        drive_nxt.rectifier_drive_b = cmp_s.ss_done & half_w & dls_vld_r
            & st_nxt != cmps_pkg::S_IDLE
            & ~(busy_w & which_b_nxt);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= cmps_pkg::S_IDLE;
            dcnt_r <= 8'h00;
            on_cnt_r <= 16'h0000;
            prev_on_r <= 16'h0000;
            which_b_r <= 1'b0;
            nxt_b_r <= 1'b0;
            skip_pair_r <= 1'b0;
            drive_o <= '0;
            ocp_event_o <= 1'b0;
            skip_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            dcnt_r <= dcnt_nxt;
            on_cnt_r <= on_cnt_nxt;
            prev_on_r <= prev_on_nxt;
            which_b_r <= which_b_nxt;
            nxt_b_r <= nxt_b_nxt;
            skip_pair_r <= skip_pair_nxt;
            drive_o <= drive_nxt;
            ocp_event_o <= ocp_nxt;
            skip_o <= skip_nxt;
        end
    end

    // Checks on the drive sequence
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_skip_req;
        take_w && skip_go_w;
    endsequence

    sequence s_ilim_hit;
        st_r == cmps_pkg::S_ON && cmp_s.ilim && past_blank_w;
    endsequence

    a_rect_ss_off: assert property (
        !cmp_s.ss_done |=> !drive_o.rectifier_drive_a
            && !drive_o.rectifier_drive_b)
        else $error("rectifier on before soft start end");
    a_rectb_half_only: assert property (
        !half_w |=> !drive_o.rectifier_drive_b)
        else $error("second rectifier on outside half mode");
    a_primb_half_only: assert property (
        !half_w |=> !drive_o.primary_drive_b)
        else $error("second primary on outside half mode");
    a_no_overlap: assert property (
        !(drive_o.primary_drive_a && drive_o.rectifier_drive_a)
        && !(drive_o.primary_drive_b && drive_o.rectifier_drive_b))
        else $error("primary and rectifier high together");
    a_dead_before_rise: assert property (
        $rose(drive_o.primary_drive_a) && $past(cmp_s.ss_done, 2)
        |-> !$past(drive_o.rectifier_drive_a))
        else $error("no dead time before primary rise");
    a_min_on_time: assert property (
        st_r == cmps_pkg::S_ON && !start_pend_r && !lim_hit_w
        && !past_blank_w |=> st_r == cmps_pkg::S_ON)
        else $error("pulse ended inside blanking");
    a_ocp_trip: assert property (
        s_ilim_hit |=> ocp_event_o && !drive_o.primary_drive_a
            && !drive_o.primary_drive_b)
        else $error("current limit did not end pulse");
    a_skip_pulse: assert property (
        s_skip_req |=> skip_o && st_r == cmps_pkg::S_REST
            && !drive_o.primary_drive_a && !drive_o.primary_drive_b)
        else $error("skip condition did not skip");
    a_alt_primaries: assert property (
        !(drive_o.primary_drive_a && drive_o.primary_drive_b))
        else $error("both primaries high");

endmodule : cmps_top

/* test/cmps_gate_model.sv */
`timescale 1ns/100ps
module cmps_gate_model (
    input wire logic clk_i,
    input wire logic sync_en_i,
    input wire cmps_pkg::cmps_drive_t drive_i,
    output logic sync_clk_o,
    output logic [3:0] gate_o
);
    int cnt;
    // Twice-rate sync clock, held low while disabled
    initial begin
        sync_clk_o = 1'b0;
        cnt = 0;
        forever begin
            @(posedge clk_i);
            #1;
            cnt = sync_en_i ? (cnt + 1) % 20 : 0;
            if (cnt == 0) sync_clk_o = sync_en_i & ~sync_clk_o;
        end
    end
    // Gate stages follow the drive levels one cycle late
    always_ff @(posedge clk_i) gate_o <= drive_i;
endmodule : cmps_gate_model

/* test/tb.sv */
`timescale 1ns/100ps
module tb;
    logic clk, rst_b, osc, sync_en, sync_clk, ocp, skp;
    logic [3:0] gate;
    cmps_pkg::cmps_cfg_t cfg;
    cmps_pkg::cmps_cmp_t cmp;
    cmps_pkg::cmps_drive_t drv;
    int miscompares, total_checks, ra_low, pa_low, pa_on;
    logic [1:0] expq[$];
    wire logic ovl = (gate[3] & gate[1]) | (gate[2] & gate[0])
        | (gate[3] & gate[2]);
    cmps_top i_dut (.clk_i(clk), .rst_b_i(rst_b), .cfg_i(cfg),
        .cmp_i(cmp), .sync_clk_i(sync_clk), .osc_clk_i(osc),
        .drive_o(drv), .ocp_event_o(ocp), .skip_o(skp));
    cmps_gate_model i_gate (.clk_i(clk), .sync_en_i(sync_en),
        .drive_i(drv), .sync_clk_o(sync_clk), .gate_o(gate));
    // System clock and twice-rate oscillator
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        osc = 1'b0;
        forever #200 osc = ~osc;
    end
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic chk_ev(input logic [1:0] g);
        logic [1:0] e;
        e = (expq.size() > 0) ? expq.pop_front() : 2'h0;
        chk("event", {6'h0, e}, {6'h0, g});
    endtask : chk_ev
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // Reset with a new strap; strap is only taken after release
    task automatic restart(input logic [1:0] strap);
        @(posedge clk);
        #1;
        rst_b = 1'b0;
        cfg.duty_limit_select = strap;
        repeat (10) @(posedge clk);
        #1;
        chk("reset", 8'h0, {4'h0, drv});
        rst_b = 1'b1;
    endtask : restart
    // Event notes popped as pulses appear; overlap guard on the gates
    always @(negedge clk) begin
        if (ocp === 1'b1 || skp === 1'b1) chk_ev({ocp, skp});
        if (rst_b) chk("overlap", 8'h0, {7'h0, ovl});
    end
    // Run lengths of drive levels
    always @(posedge clk) begin
        ra_low <= drv.rectifier_drive_a ? 0 : ra_low + 1;
        pa_low <= drv.primary_drive_a ? 0 : pa_low + 1;
        pa_on <= drv.primary_drive_a ? pa_on + 1 : 0;
    end
    // Main sequence
    initial begin
        int da, db, bl;
        rst_b = 1'b0;
        sync_en = 1'b0;
        cfg = '0;
        cmp = '0;
        da = $urandom(32'h6c8a);
        cfg.dead_float = 1'b1;
        cmp.pwm_trip = 1'b1;
        restart(cmps_pkg::DLS_GND);
        repeat (4) begin
            @(posedge drv.primary_drive_b);
            #1;
            chk("rect_ss", 8'h0, {6'h0, drv.rectifier_drive_a,
                drv.rectifier_drive_b});
        end
        $display("soft start half duty test done");
        cmp.ss_done = 1'b1;
        for (int k = 0; k < 3; k++) begin
            cfg.dead_float = (k == 0);
            cfg.blank_fixed = (k == 2);
            cfg.dead_time_a_set = 4'(2 + $urandom % 6);
            cfg.dead_time_b_set = 4'(2 + $urandom % 6);
            cfg.blank_time_set = 8'(4 + $urandom % 6);
            da = (k == 0) ? 1 : cfg.dead_time_a_set;
            db = (k == 0) ? 1 : cfg.dead_time_b_set;
            bl = cfg.blank_time_set;
            if (k == 0) da = cmps_pkg::DEAD_MIN_CYC;
            if (k == 0) db = cmps_pkg::DEAD_MIN_CYC;
            if (k == 2) da = cmps_pkg::FIXED_CYC;
            if (k == 2) db = cmps_pkg::FIXED_CYC;
            if (k == 2) bl = cmps_pkg::FIXED_CYC;
            repeat (3) @(posedge drv.primary_drive_a);
            #1;
            chk("lead", 8'(db), 8'(ra_low));
            @(negedge drv.primary_drive_a);
            #1;
            chk("min_on", 8'h1, {7'h0, pa_on > bl});
            @(posedge drv.rectifier_drive_a);
            #1;
            chk("trail", 8'(da), 8'(pa_low));
        end
        $display("dead time test done");
        cmp.pwm_trip = 1'b0;
        @(posedge drv.primary_drive_a);
        #1;
        expq.push_back(2'h2);
        cmp.ilim = 1'b1;
        @(posedge ocp);
        #1;
        cmp.ilim = 1'b0;
        repeat (2) @(negedge clk);
        chk("ocp_end", 8'h0, {7'h0, drv.primary_drive_a});
        @(posedge clk);
        #1;
        cmp.pwm_trip = 1'b1;
        $display("current limit test done");
        // External sync at full duty, short pulses, then a skip
        cfg.ext_sync_mode = 1'b1;
        sync_en = 1'b1;
        restart(cmps_pkg::DLS_RAIL);
        repeat (3) @(posedge drv.primary_drive_a);
        @(negedge drv.primary_drive_a);
        #1;
        expq.push_back(2'h1);
        cmp.comp_low = 1'b1;
        @(posedge skp);
        #1;
        cmp.comp_low = 1'b0;
        chk("skip_rect", 8'h1, {6'h0, drv.primary_drive_a,
            drv.rectifier_drive_a});
        repeat (200) begin
            @(negedge clk);
            chk("b_off", 8'h0, {6'h0, drv.primary_drive_b,
                drv.rectifier_drive_b});
        end
        chk("notes_left", 8'h0, 8'(expq.size()));
        $display("skip and full duty test done");
        // Open strap with external clock: pulse cut at 75 percent of 80
        restart(cmps_pkg::DLS_FLOAT);
        cmp.pwm_trip = 1'b0;
        repeat (2) @(negedge drv.primary_drive_a);
        #1;
        chk("lim75", 8'h1, {7'h0, pa_on > 40 && pa_on <= 60});
        $display("three quarter duty test done");
        complete_run();
    end
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
endmodule : tb
